/* hw/mid_pkg.sv */
// package: instruction word layout, opcode classes and timing constants for the decoder
`default_nettype none
package mid_pkg;
  // word and field widths
  localparam int WORD_W = 14;
  localparam int FILE_W = 7;
  localparam int BIT_W = 3;
  localparam int LIT8_W = 8;
  localparam int LIT11_W = 11;
  // field positions
  localparam int DEST_POS = 7;
  localparam int BIT_LSB = 7;
  localparam int GRP_LSB = 12;
  localparam int SUB_LSB = 8;
  // oscillator periods per instruction cycle
  localparam int QUARTERS = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_RST = 2'h0;
  // reset values and the nop word for flushed slots
  localparam logic [13:0] WORD_RST = 14'h0000;
  localparam logic [13:0] NOP_WORD = 14'h0000;
  localparam logic [7:0] ACC_RST = 8'h00;
  // opcode groups (two top bits)
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_JUMP = 2'h2;
  localparam logic [1:0] GRP_LIT = 2'h3;
  // byte group sub-codes (bits 11:8)
  localparam logic [3:0] SUB_MISC = 4'h0;
  localparam logic [3:0] SUB_DECSZ = 4'hb;
  localparam logic [3:0] SUB_INCSZ = 4'hf;
  // bit group sub-codes (bits 11:10)
  localparam logic [1:0] BSUB_SKIPCLR = 2'h2;
  localparam logic [1:0] BSUB_SKIPSET = 2'h3;
  // literal group sub-codes (bits 11:9 for add, bits 11:10 for return-literal)
  localparam logic [2:0] LSUB_ADD = 3'h7;
  localparam logic [1:0] LSUB_RETLIT = 2'h1;
  // control words with all-zero upper byte
  localparam logic [7:0] LOW_RETURN = 8'h08;
  localparam logic [7:0] LOW_RETINT = 8'h09;
  // operation classes handed downstream
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_BYTE = 3'h1,
    OP_BIT = 3'h2,
    OP_LIT = 3'h3,
    OP_BRANCH = 3'h4,
    OP_ADDLIT = 3'h5
  } mid_class_t;
  // instruction cycle state
  typedef enum logic [0:0] {
    ST_EXEC = 1'h0,
    ST_FLUSH = 1'h1
  } mid_state_t;
endpackage
`default_nettype wire

/* hw/mid_phase.sv */
// quarter-cycle counter: four oscillator periods form one instruction cycle
`default_nettype none
module mid_phase
  import mid_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // phase outputs
  output logic [1:0] phase_out,
  output logic cycle_end_out
);
  logic [1:0] next_phase;

  // wrap after the fourth period
  assign next_phase = (phase_out == PHASE_LAST) ? PHASE_RST : phase_out + 2'h1;
  assign cycle_end_out = (phase_out == PHASE_LAST);

  // phase register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_out <= PHASE_RST;
    end else begin
      phase_out <= next_phase;
    end
  end
endmodule
`default_nettype wire

/* hw/mid_decode.sv */
// instruction decoder: field extraction, two-cycle timing and literal add
// Operation
// - every instruction is one 14-bit word split into an opcode and operand fields.
// - for byte operations destination bit 0 steers the result to the accumulator, 1 to the file.
// - the file field of byte and bit operations addresses locations 0x00 to 0x7f.
// - bit operations carry a 3-bit field naming one bit of the 8-bit file register.
// - literal and control operations carry an 8-bit data or 11-bit target literal.
// - don't-care opcode bits never change the decoded operation.
// - one cycle per instruction, two when a skip succeeds or the counter changes, the second a nop.
// - one instruction cycle is four oscillator periods.
// - add-literal adds its 8-bit literal to the accumulator and updates carry, digit carry, zero.
`default_nettype none
module mid_decode
  import mid_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // instruction word from program memory, sampled at cycle end
  input wire logic [13:0] word_in,
  // skip condition result from the datapath for the current word
  input wire logic skip_true_in,
  // decoded fields
  output logic [2:0] class_out,
  output logic [6:0] file_addr_out,
  output logic dest_file_out,
  output logic dest_acc_out,
  output logic [2:0] bit_num_out,
  output logic [7:0] lit8_out,
  output logic [10:0] lit11_out,
  output logic branch_out,
  output logic skip_op_out,
  // timing
  output logic [1:0] phase_out,
  output logic cycle_end_out,
  output logic flush_out,
  // accumulator and flags for add-literal
  output logic [7:0] acc_out,
  output logic carry_out,
  output logic digit_carry_out,
  output logic zero_out
);
  logic [13:0] word;
  mid_state_t state;
  mid_state_t next_state;
  logic [1:0] phase;
  logic cyc_end;
  logic [1:0] grp;
  logic [3:0] sub;
  logic [7:0] low;
  logic is_byte, is_bit, is_jump, is_lit, is_retlit, is_ret, is_retint, is_addlit;
  logic is_skip_op, is_pc_change, two_cycle;
  mid_class_t next_class;
  logic [8:0] sum;
  logic [4:0] nib_sum;

  mid_phase u_phase (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .phase_out(phase),
    .cycle_end_out(cyc_end)
  );

  // opcode split of the current word
  assign grp = word[13:GRP_LSB];
  assign sub = word[11:SUB_LSB];
  assign low = word[7:0];
  assign is_byte = (grp == GRP_BYTE);
  assign is_bit = (grp == GRP_BIT);
  assign is_jump = (grp == GRP_JUMP);
  assign is_lit = (grp == GRP_LIT);
  // don't-care bit 8 is left out of both compares, bit 9 only out of the return-literal one
  assign is_addlit = is_lit && (sub[3:1] == LSUB_ADD);
  assign is_retlit = is_lit && (sub[3:2] == LSUB_RETLIT);
  assign is_ret = is_byte && (sub == SUB_MISC) && (low == LOW_RETURN);
  assign is_retint = is_byte && (sub == SUB_MISC) && (low == LOW_RETINT);
  assign is_skip_op = (is_byte && (sub == SUB_DECSZ || sub == SUB_INCSZ))
    || (is_bit && (sub[3:2] == BSUB_SKIPCLR || sub[3:2] == BSUB_SKIPSET));
  assign is_pc_change = is_jump || is_retlit || is_ret || is_retint;
  // two cycles when the counter changes or a skip test succeeds
  assign two_cycle = is_pc_change || (is_skip_op && skip_true_in);

  // class selection
  assign next_class = (state == ST_FLUSH) ? OP_NONE
    : is_addlit ? OP_ADDLIT
    : is_pc_change ? OP_BRANCH
    : is_lit ? OP_LIT
    : is_bit ? OP_BIT
    : OP_BYTE;

  // second cycle always follows a two-cycle word
  assign next_state = (state == ST_EXEC && two_cycle) ? ST_FLUSH : ST_EXEC;

  // add-literal arithmetic
  assign sum = {1'b0, acc_out} + {1'b0, word[7:0]};
  assign nib_sum = {1'b0, acc_out[3:0]} + {1'b0, word[3:0]};

  // instruction latch: a flushed slot is replaced by a nop
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      word <= WORD_RST;
    end else if (cyc_end) begin
      word <= (next_state == ST_FLUSH) ? NOP_WORD : word_in;
    end
  end

  // instruction cycle state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= ST_EXEC;
    end else if (cyc_end) begin
      case (state)
        ST_EXEC: state <= next_state;
        ST_FLUSH: state <= ST_EXEC;
        default: state <= ST_EXEC;
      endcase
    end
  end

  // registered field outputs for the current word
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      class_out <= OP_NONE;
      file_addr_out <= 7'h00;
      dest_file_out <= 1'b0;
      dest_acc_out <= 1'b0;
      bit_num_out <= 3'h0;
      lit8_out <= 8'h00;
      lit11_out <= 11'h000;
      branch_out <= 1'b0;
      skip_op_out <= 1'b0;
    end else begin
      class_out <= next_class;
      file_addr_out <= word[FILE_W-1:0];
      // only a real byte operation steers a result; flush slots and returns write nowhere
      dest_file_out <= (next_class == OP_BYTE) && word[DEST_POS];
      dest_acc_out <= (next_class == OP_BYTE) && !word[DEST_POS];
      bit_num_out <= word[BIT_LSB+BIT_W-1:BIT_LSB];
      lit8_out <= word[LIT8_W-1:0];
      lit11_out <= word[LIT11_W-1:0];
      branch_out <= (state == ST_EXEC) && is_pc_change;
      skip_op_out <= (state == ST_EXEC) && is_skip_op;
    end
  end

  // timing outputs
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_out <= PHASE_RST;
      cycle_end_out <= 1'b0;
      flush_out <= 1'b0;
    end else begin
      phase_out <= phase;
      cycle_end_out <= cyc_end;
      flush_out <= (state == ST_EXEC) && two_cycle;
    end
  end

  // accumulator and flags, written at the end of an add-literal cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      acc_out <= ACC_RST;
      carry_out <= 1'b0;
      digit_carry_out <= 1'b0;
      zero_out <= 1'b0;
    end else if (cyc_end && state == ST_EXEC && is_addlit) begin
      acc_out <= sum[7:0];
      carry_out <= sum[8];
      digit_carry_out <= nib_sum[4];
      zero_out <= (sum[7:0] == 8'h00);
    end
  end
endmodule
`default_nettype wire

/* tb/mid_chk.sv */
// checker: decoder timing, flush and field relations
`default_nettype none
module mid_chk
  import mid_pkg::*;
(
  // clock, reset and flags
  input wire logic clk_in, rst_in, dest_file_out, dest_acc_out, branch_out, flush_out,
  input wire logic cycle_end_out, carry_out, zero_out,
  // fields and accumulator
  input wire logic [2:0] class_out, bit_num_out,
  input wire logic [6:0] file_addr_out,
  input wire logic [7:0] lit8_out, acc_out,
  input wire logic [10:0] lit11_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  chk_cycle_four:
    assert property (cycle_end_out |=> !cycle_end_out [*3] ##1 cycle_end_out) else $error("gap");
  chk_dest_pick:
    assert property (class_out == OP_BYTE ? dest_file_out != dest_acc_out
      : !(dest_file_out || dest_acc_out)) else $error("dest");
  chk_field_hold:
    assert property (!$past(cycle_end_out) && !$past(rst_in, 2)
      |-> $stable(lit11_out) && $stable(class_out)) else $error("moved");
  chk_field_slice:
    assert property (file_addr_out == lit11_out[6:0] && bit_num_out == lit11_out[9:7]
      && lit8_out == lit11_out[7:0]) else $error("slice");
  chk_branch_flush:
    assert property (branch_out |-> flush_out) else $error("flush");
  chk_flush_nop:
    assert property (flush_out && cycle_end_out |=> class_out == OP_NONE) else $error("nop");
  chk_add_sum:
    assert property (cycle_end_out && class_out == OP_ADDLIT |-> {carry_out, acc_out} ==
      {1'b0, $past(acc_out)} + 9'(lit8_out) && zero_out == (acc_out == 8'h00)) else $error("sum");
  chk_acc_cause:
    assert property ($changed(acc_out) |-> cycle_end_out && class_out == OP_ADDLIT)
      else $error("acc");
  cover property (flush_out && cycle_end_out);
  cover property (cycle_end_out && class_out == OP_ADDLIT && carry_out);
  cover property (dest_acc_out);
endmodule
bind mid_decode mid_chk u_chk (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .dest_file_out(dest_file_out),
  .dest_acc_out(dest_acc_out),
  .branch_out(branch_out),
  .flush_out(flush_out),
  .cycle_end_out(cycle_end_out),
  .carry_out(carry_out),
  .zero_out(zero_out),
  .class_out(class_out),
  .bit_num_out(bit_num_out),
  .file_addr_out(file_addr_out),
  .lit8_out(lit8_out),
  .acc_out(acc_out),
  .lit11_out(lit11_out)
);
`default_nettype wire

/* tb/mid_mem.sv */
// program memory model: one 14-bit word per instruction cycle
`default_nettype none
module mid_mem (
  // clock, reset and fetch strobe
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic fetch_in,
  // word offered to the decoder
  output logic [13:0] word_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [13:0] mem [0:15];
  logic [3:0] pc;
  // step on once the decoder takes a word
  always_ff @(posedge clk_in) begin
    if (rst_in) pc <= 4'h0;
    else if (fetch_in) pc <= pc + 4'h1;
  end
  assign word_out = mem[pc];
endmodule
`default_nettype wire

/* tb/testbench.sv */
// testbench: words from the memory model, decoded fields compared
`default_nettype none
module testbench
  import mid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0, rst_in = 1'b1, skip_true_in = 1'b0;
  logic [13:0] word_in;
  logic [10:0] lit11_out;
  logic [7:0] lit8_out, acc_out;
  logic [6:0] file_addr_out;
  logic [2:0] class_out, bit_num_out;
  logic [1:0] phase_out;
  logic dest_file_out, dest_acc_out, branch_out, skip_op_out, cycle_end_out, flush_out;
  logic carry_out, digit_carry_out, zero_out;
  int fails = 0, total_checks = 0;
  // packed views of the outputs
  wire logic [13:0] ops = {class_out, branch_out, flush_out, skip_op_out, lit8_out};
  wire logic [13:0] fld = {2'h0, dest_file_out, dest_acc_out, bit_num_out, file_addr_out};
  wire logic [13:0] acv = {3'h0, carry_out, digit_carry_out, zero_out, acc_out};
  always #50 clk_in = ~clk_in;
  mid_decode u_dut (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .word_in(word_in),
    .skip_true_in(skip_true_in),
    .class_out(class_out),
    .file_addr_out(file_addr_out),
    .dest_file_out(dest_file_out),
    .dest_acc_out(dest_acc_out),
    .bit_num_out(bit_num_out),
    .lit8_out(lit8_out),
    .lit11_out(lit11_out),
    .branch_out(branch_out),
    .skip_op_out(skip_op_out),
    .phase_out(phase_out),
    .cycle_end_out(cycle_end_out),
    .flush_out(flush_out),
    .acc_out(acc_out),
    .carry_out(carry_out),
    .digit_carry_out(digit_carry_out),
    .zero_out(zero_out)
  );
  mid_mem u_mem (.clk_in, .rst_in, .fetch_in(cycle_end_out), .word_out(word_in));
  task chk(input string n, input logic [13:0] e, s);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task test_done;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // next cycle end, then one edge more for the fields
  task nxt;
    int i;
    for (i = 0; i < 9 && cycle_end_out !== 1'b1; i++) @(negedge clk_in);
    if (i == 9) begin
      fails++;
      test_done;
    end
    @(negedge clk_in);
  endtask
  // byte and bit fields
  task t_fields;
    nxt;
    chk("ops", 14'h0885, ops);
    chk("fld", 14'h0b85, fld);
    nxt;
    chk("fld", 14'h0705, fld);
    nxt;
    chk("fld", 14'h03ff, fld);
    chk("phase", 14'h0000, 14'(phase_out));
    @(negedge clk_in);
    chk("phase", 14'h0001, 14'(phase_out));
  endtask
  // goto, then a nop slot
  task t_jump;
    nxt;
    chk("ops", 14'h2605, ops);
    chk("target", 14'h0705, 14'(lit11_out));
    nxt;
    chk("ops", 14'h0000, ops);
  endtask
  // add-literal chain
  task t_add;
    nxt;
    nxt;
    chk("ops", 14'h2818, ops);
    chk("acc", 14'h00f8, acv);
    nxt;
    chk("acc", 14'h0610, acv);
  endtask
  // taken and untaken skip
  task t_skip;
    @(posedge clk_in) skip_true_in <= 1'b1;
    nxt;
    chk("acc", 14'h0500, acv);
    nxt;
    chk("ops", 14'h0000, ops);
    @(posedge clk_in) skip_true_in <= 1'b0;
    nxt;
    chk("ops", 14'h0985, ops);
    nxt;
    chk("fld", 14'h0bff, fld);
  endtask
  // return with literal and plain return, each with its fetched word dropped
  task t_ret;
    nxt;
    chk("ops", 14'h2608, ops);
    nxt;
    chk("ops", 14'h0000, ops);
    chk("fld", 14'h0000, fld);
    nxt;
    chk("fld", 14'h0008, fld);
    chk("ops", 14'h2608, ops);
    chk("acc", 14'h0500, acv);
    nxt;
    chk("ops", 14'h0000, ops);
  endtask
  // main sequence
  initial begin
    u_mem.mem = '{14'h0785, 14'h0705, 14'h17ff, 14'h2f05, 14'h3e10, 14'h3ef8, 14'h3f18,
      14'h3ff0, 14'h0b85, 14'h07ff, 14'h0b85, 14'h07ff, 14'h3508, 14'h3e01, 14'h0008, 14'h3e01};
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    t_fields;
    t_jump;
    t_add;
    t_skip;
    t_ret;
    test_done;
  end
endmodule
`default_nettype wire
